// ### rtl/sac_converter.sv
// Converter end: start handling, successive approximation sequencer and three-state result groups
//
// Function
// - Host holds start high at least 500 ns
// - Start rising resets logic, clears old result
// - Ready goes high within 1.5 us
// - Ready high means approximation register reset done
// - Approximation begins on start falling edge, or at ready high if start fell during reset
// - Ready returns low when conversion finishes
// - Host keeps both enables high during conversion
// - Enable during conversion shows partial result bits
// - Each group drives only while enable low
// - Upper enable eight bits, lower two, independent
// - Result left-justified: upper eight MSBs, lower two
// - Host masks six meaningless low-read bits
// - Host derives start and enables from strobes
// - Base write starts; base read gives upper
// - Base plus one: writes ignored, reads lower
// - Without monitoring, wait 30 us before reading
// - Host may poll ready or use falling edge
// - Sample-hold mode: wait 10 us before restart
`include "sac_defines.svh"

module sac_converter (
	input  wire logic                  core_clk,	// System clock, 20 MHz
	input  wire logic                  reset,	// Synchronous reset, active high
	input  wire logic [`SAC_RES_W-1:0] analog_code,	// Digitised analog level the comparator weighs
	output logic                       busy,	// High while a conversion cycle runs
	sac_link_if.dev                    link	// Pins toward the bus-side controller
);
	import sac_pkg::*;

	sac_dev_type s_r;	// Registered state
	sac_dev_type s_nxt;	// Next state

	// Bit mask selecting one position of the result
	function automatic logic [`SAC_RES_W-1:0] bit_mask(input logic [3:0] idx);
		logic [`SAC_RES_W-1:0] m;
		m = '0;
		m[idx] = 1'b1;
		return m;
	endfunction

	// Comparator decision: keep the trial bit when the trial does not exceed the input
	function automatic logic [`SAC_RES_W-1:0] decide(
		input logic [`SAC_RES_W-1:0] trial,
		input logic [3:0]            idx,
		input logic [`SAC_RES_W-1:0] level
	);
		logic [`SAC_RES_W-1:0] r;
		r = trial;
		if (trial > level) begin
			r = trial & ~bit_mask(idx);
		end
		return r;
	endfunction

	logic start_rise;	// Start line went high this cycle
	logic start_fall;	// Start line went low this cycle

	// Edge detection on the start line; it comes from logic on this same clock
	assign start_rise = link.convert & ~s_r.conv_d;
	assign start_fall = ~link.convert & s_r.conv_d;

	// Sequencer next state
	always_comb begin
		s_nxt        = s_r;
		s_nxt.conv_d = link.convert;
		case (s_r.state)
			SAC_DEV_IDLE: begin
				// Nothing to do until a start pulse arrives
				s_nxt.ready_n = s_r.ready_n;
			end
			SAC_DEV_CLEAR: begin
				// Reset interval; a fall that lands here is remembered, not lost
				if (start_fall) begin
					s_nxt.fell = 1'b1;
				end
				if (s_r.cnt == 10'(`SAC_DSC_CYC - 1)) begin
					s_nxt.ready_n = 1'b1;
					s_nxt.cnt     = '0;
					// Ready high only now that the register is clear
					if (s_r.fell || start_fall || !link.convert) begin
						s_nxt.state   = SAC_DEV_CONV;
						s_nxt.bit_idx = `SAC_TOP_BIT;
						s_nxt.sar     = bit_mask(`SAC_TOP_BIT);
					end else begin
						s_nxt.state = SAC_DEV_HOLD;
					end
				end else begin
					s_nxt.cnt = s_r.cnt + 10'h001;
				end
			end
			SAC_DEV_HOLD: begin
				// Approximation waits for the trailing edge of start
				if (!link.convert) begin
					s_nxt.state   = SAC_DEV_CONV;
					s_nxt.bit_idx = `SAC_TOP_BIT;
					s_nxt.sar     = bit_mask(`SAC_TOP_BIT);
					s_nxt.cnt     = '0;
				end
			end
			SAC_DEV_CONV: begin
				// One decision per bit period, most significant bit first
				if (s_r.cnt == 10'(`SAC_BIT_CYC - 1)) begin
					s_nxt.cnt = '0;
					s_nxt.sar = decide(s_r.sar, s_r.bit_idx, analog_code);
					if (s_r.bit_idx == 4'h0) begin
						s_nxt.state   = SAC_DEV_IDLE;
						s_nxt.ready_n = 1'b0;
					end else begin
						// Next trial bit set on top of the decided ones
						s_nxt.bit_idx = s_r.bit_idx - 4'h1;
						s_nxt.sar     = decide(s_r.sar, s_r.bit_idx, analog_code)
							| bit_mask(s_r.bit_idx - 4'h1);
					end
				end else begin
					s_nxt.cnt = s_r.cnt + 10'h001;
				end
			end
			default: begin
				// Unknown code recovers to idle
				s_nxt.state = SAC_DEV_IDLE;
			end
		endcase
		// A new start wins over anything in progress, also mid-conversion
		if (start_rise) begin
			s_nxt.state   = SAC_DEV_CLEAR;
			s_nxt.sar     = `SAC_RES_RESET;
			s_nxt.cnt     = '0;
			s_nxt.fell    = 1'b0;
			s_nxt.bit_idx = `SAC_TOP_BIT;
		end
	end

	// State register; reset leaves a clear result with ready low, as after power-up idle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_r.state   <= SAC_DEV_IDLE;
			s_r.sar     <= `SAC_RES_RESET;
			s_r.bit_idx <= `SAC_TOP_BIT;
			s_r.cnt     <= '0;
			s_r.conv_d  <= 1'b0;
			s_r.fell    <= 1'b0;
			s_r.ready_n <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Ready pin straight from its flip-flop
	assign link.result_ready_n = s_r.ready_n;

	// Result groups come from the register at all times, so an early read sees partial bits
	assign link.upper_data = s_r.sar[`SAC_UP_MSB:`SAC_UP_LSB];
	assign link.lower_data = s_r.sar[`SAC_LO_MSB:`SAC_LO_LSB];

	// Each group follows its own enable; no interlock with conversion, so bus clashes are the host's duty
	assign link.upper_data_oe_n = link.upper_byte_output_enable_n;
	assign link.lower_data_oe_n = link.lower_byte_output_enable_n;

	// Busy covers reset and approximation, for user-side observers
	assign busy = (s_r.state != SAC_DEV_IDLE);

endmodule // sac_converter

// ### rtl/sac_defines.svh
// Timing counts, widths, field positions and host locations shared by both ends of the converter link
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// Clock period of core_clk in nanoseconds (20 MHz)
`define SAC_CLK_PERIOD_NS   50

// Result layout: ten bits, upper group of eight, lower group of two
`define SAC_RES_W           10
`define SAC_UP_W            8
`define SAC_LO_W            2
`define SAC_UP_MSB          9
`define SAC_UP_LSB          2
`define SAC_LO_MSB          1
`define SAC_LO_LSB          0
`define SAC_TOP_BIT         4'h9
`define SAC_LO_MASK         8'hc0
`define SAC_RES_RESET       10'h000

// Host-side locations: base starts and reads upper byte, base plus one reads lower group
`define SAC_ADDR_BASE       1'b0
`define SAC_ADDR_LOW        1'b1

// Least start pulse width, rounded up to whole cycles
`define SAC_T_CS_NS         500
`define SAC_CS_CYC          ((`SAC_T_CS_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)

// Ready deassert delay after start rises: typical used, longest bound rounds down
`define SAC_READY_DEASSERT_DELAY_NS        1000
`define SAC_READY_DEASSERT_DELAY_MAX_NS    1500
`define SAC_DSC_CYC         (`SAC_READY_DEASSERT_DELAY_NS / `SAC_CLK_PERIOD_NS)
`define SAC_DSC_MAX_CYC     (`SAC_READY_DEASSERT_DELAY_MAX_NS / `SAC_CLK_PERIOD_NS)

// Conversion time (typical) and the share of it spent per bit decision
`define SAC_T_CONV_NS       20000
`define SAC_CONV_CYC        (`SAC_T_CONV_NS / `SAC_CLK_PERIOD_NS)
`define SAC_BIT_CYC         (`SAC_CONV_CYC / `SAC_RES_W)

// Host wait without monitoring: longest conversion, a least time, rounded up
`define SAC_T_WAIT_NS       30000
`define SAC_WAIT_CYC        ((`SAC_T_WAIT_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)

// Sample-hold acquisition after completion, a least time, rounded up
`define SAC_T_ACQ_NS        10000
`define SAC_ACQ_CYC         ((`SAC_T_ACQ_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)

// Output buffer access time, a least wait for the host, rounded up
`define SAC_T_ACCESS_NS     250
`define SAC_ACC_CYC         ((`SAC_T_ACCESS_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)

`endif

// ### rtl/sac_pkg.sv
// Types for both ends of the converter link: states and the packed state records
`include "sac_defines.svh"

package sac_pkg;

	// Converter end sequencing
	typedef enum logic [2:0] {
		SAC_DEV_IDLE  = 3'h0,	// Waiting for a start pulse
		SAC_DEV_CLEAR = 3'h1,	// Internal logic being reset
		SAC_DEV_HOLD  = 3'h2,	// Reset done, start still high
		SAC_DEV_CONV  = 3'h3	// Bit-by-bit approximation
	} sac_dev_state_type;

	// Bus-side controller sequencing
	typedef enum logic [2:0] {
		SAC_HST_IDLE  = 3'h0,	// Bus may issue a request
		SAC_HST_PULSE = 3'h1,	// Start line held high
		SAC_HST_CONV  = 3'h2,	// Conversion under way, enables kept high
		SAC_HST_READ  = 3'h3	// One buffer group enabled
	} sac_hst_state_type;

	// Whole state of the converter end
	typedef struct packed {
		sac_dev_state_type          state;	// Sequencer state
		logic [`SAC_RES_W-1:0]      sar;	// Approximation register
		logic [3:0]                 bit_idx;	// Bit under trial
		logic [9:0]                 cnt;	// Cycle counter
		logic                       conv_d;	// Start line one cycle ago
		logic                       fell;	// Start fell during reset
		logic                       ready_n;	// Active-low ready output
	} sac_dev_type;

	// Whole state of the bus-side controller
	typedef struct packed {
		sac_hst_state_type          state;	// Sequencer state
		logic [9:0]                 cnt;	// Cycle counter
		logic [7:0]                 rec;	// Acquisition countdown
		logic                       seen_hi;	// Ready seen high this conversion
		logic                       rd_low;	// Current read is the lower group
		logic                       convert;	// Start line
		logic                       up_en_n;	// Upper enable
		logic                       lo_en_n;	// Lower enable
		logic [`SAC_UP_W-1:0]       rdata;	// Read data to the bus
		logic                       rvalid;	// Read data strobe
		logic                       eoc;	// End-of-conversion pulse
		logic                       ready_d;	// Ready one cycle ago
	} sac_hst_type;

endpackage : sac_pkg

// ### rtl/sac_link_if.sv
// Pin-level link between the converter end and its bus-side controller
`include "sac_defines.svh"

interface sac_link_if;
	logic                  convert;	// Start pulse, active high
	logic                  upper_byte_output_enable_n;	// Upper buffer enable, low drives
	logic                  lower_byte_output_enable_n;	// Lower buffer enable, low drives
	logic                  result_ready_n;	// Low when result complete
	logic [`SAC_UP_W-1:0]  upper_data;	// Upper group value
	logic                  upper_data_oe_n;	// Upper group driven when low
	logic [`SAC_LO_W-1:0]  lower_data;	// Lower group value
	logic                  lower_data_oe_n;	// Lower group driven when low

	// Converter end
	modport dev (
		input  convert,
		input  upper_byte_output_enable_n,
		input  lower_byte_output_enable_n,
		output result_ready_n,
		output upper_data,
		output upper_data_oe_n,
		output lower_data,
		output lower_data_oe_n
	);

	// Bus-side controller end
	modport host (
		output convert,
		output upper_byte_output_enable_n,
		output lower_byte_output_enable_n,
		input  result_ready_n,
		input  upper_data,
		input  upper_data_oe_n,
		input  lower_data,
		input  lower_data_oe_n
	);
endinterface : sac_link_if

// ### rtl/sac_bus_ctrl.sv
// Bus-side controller: decodes two locations into start pulse and buffer enables, paces reads
`include "sac_defines.svh"

module sac_bus_ctrl (
	input  wire logic                 core_clk,	// System clock, 20 MHz
	input  wire logic                 reset,	// Synchronous reset, active high
	input  wire logic                 cpu_sel,	// Converter locations decoded
	input  wire logic                 cpu_addr,	// Offset: 0 base, 1 base plus one
	input  wire logic                 cpu_wr,	// Write strobe
	input  wire logic                 cpu_rd,	// Read strobe
	input  wire logic                 monitor_ready,	// Use ready line instead of fixed wait
	input  wire logic                 sha_mode,	// Sample-hold in front; add acquisition wait
	output logic                      cpu_ready,	// Request accepted this cycle when high
	output logic [`SAC_UP_W-1:0]      cpu_rdata,	// Read data
	output logic                      cpu_rvalid,	// Read data strobe, one cycle
	output logic                      cpu_eoc,	// End-of-conversion pulse
	sac_link_if.host                  link	// Pins toward the converter
);
	import sac_pkg::*;

	sac_hst_type s_r;	// Registered state
	sac_hst_type s_nxt;	// Next state

	logic take;	// A request is taken this cycle

	// Requests only in idle, and every request, read or start, waits out acquisition
	assign cpu_ready = (s_r.state == SAC_HST_IDLE) && (s_r.rec == 8'h00);
	assign take      = cpu_ready && cpu_sel && (cpu_wr || cpu_rd);

	// Sequencer next state
	always_comb begin
		s_nxt         = s_r;
		s_nxt.rvalid  = 1'b0;
		s_nxt.ready_d = link.result_ready_n;
		// Falling ready is the completion event
		s_nxt.eoc     = s_r.ready_d && !link.result_ready_n;
		if (s_r.rec != 8'h00) begin
			s_nxt.rec = s_r.rec - 8'h01;
		end
		case (s_r.state)
			SAC_HST_IDLE: begin
				if (take && cpu_wr && cpu_addr == `SAC_ADDR_BASE) begin
					// Any value written to base starts; data is not looked at
					s_nxt.state   = SAC_HST_PULSE;
					s_nxt.convert = 1'b1;
					s_nxt.cnt     = '0;
					s_nxt.seen_hi = 1'b0;
				end else if (take && cpu_rd) begin
					s_nxt.state   = SAC_HST_READ;
					s_nxt.rd_low  = (cpu_addr == `SAC_ADDR_LOW);
					s_nxt.up_en_n = (cpu_addr == `SAC_ADDR_LOW);
					s_nxt.lo_en_n = (cpu_addr == `SAC_ADDR_BASE);
					s_nxt.cnt     = '0;
				end
				// Write to base plus one falls through: taken and ignored
			end
			SAC_HST_PULSE: begin
				// Start held high for the least width
				if (s_r.cnt == 10'(`SAC_CS_CYC - 1)) begin
					s_nxt.convert = 1'b0;
					s_nxt.state   = SAC_HST_CONV;
				end
				s_nxt.cnt = s_r.cnt + 10'h001;
			end
			SAC_HST_CONV: begin
				// Enables stay high throughout; the count runs from the start edge
				if (link.result_ready_n) begin
					s_nxt.seen_hi = 1'b1;
				end
				s_nxt.cnt = s_r.cnt + 10'h001;
				if ((s_r.cnt == 10'(`SAC_WAIT_CYC - 1))
					|| (monitor_ready && s_r.seen_hi && !link.result_ready_n)) begin
					s_nxt.state = SAC_HST_IDLE;
					if (sha_mode) begin
						s_nxt.rec = 8'(`SAC_ACQ_CYC);
					end
				end
			end
			SAC_HST_READ: begin
				// Wait the buffer access time, then capture one group
				if (s_r.cnt == 10'(`SAC_ACC_CYC - 1)) begin
					s_nxt.up_en_n = 1'b1;
					s_nxt.lo_en_n = 1'b1;
					s_nxt.rvalid  = 1'b1;
					s_nxt.state   = SAC_HST_IDLE;
					if (s_r.rd_low) begin
						// Lower group lands in the top two bits, the rest forced to zero
						s_nxt.rdata = {link.lower_data, 6'h00} & `SAC_LO_MASK;
					end else begin
						s_nxt.rdata = link.upper_data;
					end
				end
				s_nxt.cnt = s_r.cnt + 10'h001;
			end
			default: begin
				// Unknown code recovers to idle with pins released
				s_nxt.state   = SAC_HST_IDLE;
				s_nxt.convert = 1'b0;
				s_nxt.up_en_n = 1'b1;
				s_nxt.lo_en_n = 1'b1;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_r.state   <= SAC_HST_IDLE;
			s_r.cnt     <= '0;
			s_r.rec     <= 8'h00;
			s_r.seen_hi <= 1'b0;
			s_r.rd_low  <= 1'b0;
			s_r.convert <= 1'b0;
			s_r.up_en_n <= 1'b1;
			s_r.lo_en_n <= 1'b1;
			s_r.rdata   <= 8'h00;
			s_r.rvalid  <= 1'b0;
			s_r.eoc     <= 1'b0;
			s_r.ready_d <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Pins and bus outputs straight from flip-flops
	assign link.convert                    = s_r.convert;
	assign link.upper_byte_output_enable_n = s_r.up_en_n;
	assign link.lower_byte_output_enable_n = s_r.lo_en_n;
	assign cpu_rdata                       = s_r.rdata;
	assign cpu_rvalid                      = s_r.rvalid;
	assign cpu_eoc                         = s_r.eoc;

endmodule // sac_bus_ctrl

// ### sim/sac_link_properties.sv
// Concurrent checks on the converter link pins, watched beside the interface
`include "sac_defines.svh"

module sac_link_properties (
	input  wire logic                 core_clk,	// System clock
	input  wire logic                 reset,	// Synchronous reset, active high
	input  wire logic                 convert,	// Start line
	input  wire logic                 upper_byte_output_enable_n,	// Upper enable
	input  wire logic                 lower_byte_output_enable_n,	// Lower enable
	input  wire logic                 result_ready_n,	// Low when result complete
	input  wire logic [`SAC_UP_W-1:0] upper_data,	// Upper group value
	input  wire logic                 upper_data_oe_n,	// Upper group drive
	input  wire logic [`SAC_LO_W-1:0] lower_data,	// Lower group value
	input  wire logic                 lower_data_oe_n	// Lower group drive
);
	timeunit 1ns;
	timeprecision 1ps;

	localparam int DSC_MAX  = `SAC_DSC_MAX_CYC;	// Longest ready deassert delay
	localparam int CONV_MIN = 200;	// Shortest conversion, 10 us
	localparam int CONV_MAX = 600;	// Longest conversion, 30 us
	logic [9:0] hi_cnt_r;	// Cycles ready has stood high
	logic [9:0] hi_cnt_nxt;	// Next count

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	// Saturating count, so a stuck ready cannot wrap back under the floor
	always_comb begin
		hi_cnt_nxt = result_ready_n ? ((hi_cnt_r == 10'h3ff) ? hi_cnt_r : hi_cnt_r + 10'h001) : 10'h000;
	end

	// Register the count
	always_ff @(posedge core_clk) begin
		hi_cnt_r <= reset ? 10'h000 : hi_cnt_nxt;
	end

	sequence start_rise_s;
		$rose(convert);
	endsequence
	sequence sar_clear_s;
		upper_data == 8'h00 && lower_data == 2'h0;
	endsequence
	sequence conv_begin_s;
		$rose(result_ready_n) && !convert;
	endsequence

	start_clears_a: assert property (start_rise_s |=> sar_clear_s)
		else $error("old result not cleared after start");
	pulse_width_a: assert property (start_rise_s |-> convert[*8] ##1 convert ##1 convert)
		else $error("start pulse shorter than ten cycles");
	// While start stays high the register must stay clear; trials only after the trailing edge
	start_hold_a: assert property (convert && $past(convert) |-> sar_clear_s)
		else $error("approximation began while start high");
	ready_rise_a: assert property (start_rise_s |-> ##[1:DSC_MAX] result_ready_n)
		else $error("ready not high in time after start");
	reset_done_a: assert property ($rose(result_ready_n) |-> upper_data[6:0] == 7'h00 && lower_data == 2'h0)
		else $error("ready high before register reset");
	first_trial_a: assert property (conv_begin_s |-> upper_data == 8'h80)
		else $error("first trial bit wrong at conversion start");
	conv_end_a: assert property ($rose(result_ready_n) |-> ##[CONV_MIN:CONV_MAX] !result_ready_n)
		else $error("conversion did not end in time");
	conv_floor_a: assert property ($fell(result_ready_n) |-> hi_cnt_r >= 10'h0c8)
		else $error("conversion ended too soon");
	// A start one cycle earlier clears the register while ready is still low, so that cycle is left out
	result_hold_a: assert property (!result_ready_n && $past(!result_ready_n) && !$past(convert)
		|-> $stable({upper_data, lower_data}))
		else $error("final result changed while idle");
	upper_drive_a: assert property (upper_data_oe_n == upper_byte_output_enable_n)
		else $error("upper group drive differs from its enable");
	lower_drive_a: assert property (lower_data_oe_n == lower_byte_output_enable_n)
		else $error("lower group drive differs from its enable");
endmodule // sac_link_properties

// ### sim/test_sar_adc_start_and_byte_readout.sv
// Self-checking bench: bus controller driving the converter end across the link
`include "sac_defines.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin failures++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end

module test_sar_adc_start_and_byte_readout;
	timeunit 1ns;
	timeprecision 1ps;

	logic       core_clk, reset;	// Clock and reset
	logic       cpu_sel, cpu_addr, cpu_wr, cpu_rd;	// Bus request
	logic       monitor_ready, sha_mode;	// Controller modes
	logic       cpu_ready, cpu_rvalid, cpu_eoc;	// Bus answers
	logic       busy;	// Converter busy level
	logic [7:0] cpu_rdata;	// Read data
	logic [9:0] analog_code, cur;	// Level in, code expected
	logic [7:0] d;	// Last read byte
	int         failures, checks_done, eoc_seen, seed, w, lim;	// Counters
	int         exp_q[$];	// Model: codes of started conversions

	sac_link_if sac_link_if_i ();
	sac_converter sac_converter_i (.core_clk(core_clk), .reset(reset), .analog_code(analog_code),
		.busy(busy), .link(sac_link_if_i));
	sac_bus_ctrl sac_bus_ctrl_i (.core_clk(core_clk), .reset(reset), .cpu_sel(cpu_sel), .cpu_addr(cpu_addr),
		.cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .monitor_ready(monitor_ready), .sha_mode(sha_mode),
		.cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .cpu_eoc(cpu_eoc),
		.link(sac_link_if_i));
	sac_link_properties sac_link_properties_i (.core_clk(core_clk), .reset(reset),
		.convert(sac_link_if_i.convert),
		.upper_byte_output_enable_n(sac_link_if_i.upper_byte_output_enable_n),
		.lower_byte_output_enable_n(sac_link_if_i.lower_byte_output_enable_n),
		.result_ready_n(sac_link_if_i.result_ready_n), .upper_data(sac_link_if_i.upper_data),
		.upper_data_oe_n(sac_link_if_i.upper_data_oe_n), .lower_data(sac_link_if_i.lower_data),
		.lower_data_oe_n(sac_link_if_i.lower_data_oe_n));

	// Clock, 50 ns period
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// Report counts and verdict, then stop
	task automatic finish_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// One bus request held until taken; reads wait for the data strobe
	task automatic bus(input logic a, input logic wr, output int waited);
		int n;
		@(posedge core_clk);
		#5;
		cpu_sel = 1'b1;
		cpu_addr = a;
		cpu_wr = wr;
		cpu_rd = !wr;
		// Ready is looked at mid-cycle, where it has settled for the coming edge
		for (n = 0; n < 2000; n++) begin
			@(negedge core_clk);
			if (cpu_ready === 1'b1) break;
		end
		@(posedge core_clk);
		waited = n;
		#5;
		cpu_sel = 1'b0;
		cpu_wr = 1'b0;
		cpu_rd = 1'b0;
		if (n == 2000) begin
			failures++;
			finish_test();
		end
		for (n = 0; n < 20 && !wr; n++) begin
			@(posedge core_clk);
			#5;
			if (cpu_rvalid === 1'b1) break;
		end
		d = cpu_rdata;
		if (n == 20) begin
			failures++;
			finish_test();
		end
	endtask

	// Pin watch after each edge settles; enables must stay high while ready is high
	always @(posedge core_clk) begin
		#1;
		if (cpu_eoc === 1'b1) eoc_seen++;
		if (!reset && sac_link_if_i.result_ready_n) begin
			`CHK("enables", 2'b11, {sac_link_if_i.upper_data_oe_n, sac_link_if_i.lower_data_oe_n})
			`CHK("busy", 1'b1, busy)
		end
		if (!reset && !sac_link_if_i.upper_data_oe_n) begin
			`CHK("upper pins", cur[9:2], sac_link_if_i.upper_data)
		end
		if (!reset && !sac_link_if_i.lower_data_oe_n) begin
			`CHK("lower pins", cur[1:0], sac_link_if_i.lower_data)
		end
	end

	// Every mode pair twice, edge codes first; level flipped after done shows no restart
	initial begin
		seed = 32'h4eb77902;
		{reset, cpu_sel, cpu_addr, cpu_wr, cpu_rd, monitor_ready, sha_mode} = 7'b1000000;
		analog_code = 10'h000;
		cur = 10'h000;
		{failures, checks_done, eoc_seen} = 0;
		repeat (4) @(posedge core_clk);
		#5;
		reset = 1'b0;
		for (int k = 0; k < 8; k++) begin
			{sha_mode, monitor_ready} = k[1:0];
			analog_code = (k == 0) ? 10'h3ff : (k == 1) ? 10'h000 : 10'($random(seed));
			exp_q.push_back(int'(analog_code));
			bus(1'b0, 1'b1, w);
			bus(1'b1, 1'b1, w);
			analog_code = ~analog_code;
			lim = (monitor_ready ? `SAC_DSC_CYC + `SAC_CONV_CYC : `SAC_WAIT_CYC) - 3 + (sha_mode ? `SAC_ACQ_CYC : 0);
			`CHK("wait", 1'b1, w >= lim)
			cur = 10'(exp_q.pop_front());
			`CHK("busy idle", 1'b0, busy)
			bus(1'b0, 1'b0, w);
			`CHK("upper byte", cur[9:2], d)
			bus(1'b1, 1'b0, w);
			`CHK("lower byte", {cur[1:0], 6'h00}, d)
		end
		`CHK("eoc count", 8, eoc_seen)
		finish_test();
	end
endmodule // test_sar_adc_start_and_byte_readout
